//--- src/pmid_mem.sv
// identification and diagnostic memory, two pages of bytes
// assumes writes from the two-wire side are checked for protection here
`timescale 1ns/1ps
`include "pmid_params.svh"
module pmid_mem
    import pmid_pkg::*;
#(
    parameter int PAGE = 256
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // write requests
    input  wire pmid_wr_t   twi_wr,
    input  wire pmid_wr_t   fac_wr,
    // read ports
    input  wire logic [8:0] twi_addr,
    input  wire logic [8:0] fac_addr,
    output logic      [7:0] twi_data,
    output logic      [7:0] fac_data,
    // live values
    input  wire pmid_diag_t diag,
    input  wire logic       txdis,
    input  wire logic       fault,
    input  wire logic       lost,
    output logic            soft_dis
);
    typedef struct packed {
        logic [2*PAGE-1:0][7:0] m;
    } pmid_mem_st_t;

    pmid_mem_st_t s;
    pmid_mem_st_t next_s;

    localparam logic [8:0] STAT_A = {1'b1, `PMID_STAT_BYTE};

    // raw readings and the status byte overlay the stored bytes
    function automatic logic [7:0] rd(input logic [8:0] a);
        logic [7:0] idx;
        logic [7:0] v;
        idx = a[7:0] - `PMID_DIAG_FIRST;
        v   = s.m[a];
        if (a[8] && a[7:0] >= `PMID_DIAG_FIRST
                 && a[7:0] <= `PMID_DIAG_LAST) begin
            v = idx[0] ? diag.word[idx[3:1]][7:0]
                       : diag.word[idx[3:1]][15:8];
        end else if (a == STAT_A) begin
            v = 8'h00;
            v[`PMID_SB_TXDIS] = txdis;
            v[`PMID_SB_SOFT]  = s.m[STAT_A][`PMID_SB_SOFT];
            v[`PMID_SB_FAULT] = fault;
            v[`PMID_SB_LOST]  = lost;
        end
        return v;
    endfunction

    // only the soft-disable bit and the user area take host writes
    function automatic logic wr_ok(input logic [8:0] a);
        return a[8] && (a == STAT_A || a[7:0] >= `PMID_USER_FIRST);
    endfunction

    always_comb begin
        next_s = s;
        if (twi_wr.en && wr_ok(twi_wr.addr)) begin
            if (twi_wr.addr == STAT_A) begin
                next_s.m[STAT_A][`PMID_SB_SOFT] =
                    twi_wr.data[`PMID_SB_SOFT];
            end else begin
                next_s.m[twi_wr.addr] = twi_wr.data;
            end
        end
        if (fac_wr.en) begin
            next_s.m[fac_wr.addr] = fac_wr.data;
        end
        twi_data = rd(twi_addr);
        fac_data = rd(fac_addr);
        soft_dis = s.m[STAT_A][`PMID_SB_SOFT];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule

//--- src/pmid_params.svh
// constants of the module identification and status block
// assumes inclusion by bare name from every file that needs them
`ifndef PMID_PARAMS_SVH
`define PMID_PARAMS_SVH

// two-wire device addresses, 7-bit form
`define PMID_DEV_ID      7'h50
`define PMID_DEV_DIAG    7'h51
// diagnostic page layout
`define PMID_CAL_FIRST   8'h38
`define PMID_CAL_LAST    8'h5F
`define PMID_DIAG_FIRST  8'h60
`define PMID_DIAG_LAST   8'h69
`define PMID_STAT_BYTE   8'h6E
`define PMID_USER_FIRST  8'h80
// bits of the live status byte
`define PMID_SB_TXDIS    7
`define PMID_SB_SOFT     6
`define PMID_SB_FAULT    2
`define PMID_SB_LOST     1
// bit counter end value
`define PMID_LAST_BIT    4'h8
// register byte offsets
`define PMID_REG_CTRL    8'h00
`define PMID_REG_STATUS  8'h04
`define PMID_REG_IRQ_ST  8'h08
`define PMID_REG_IRQ_CLR 8'h0C
`define PMID_REG_IRQ_EN  8'h10
`define PMID_REG_DIAG0   8'h14
`define PMID_REG_DIAG1   8'h18
`define PMID_REG_DIAG2   8'h1C
`define PMID_REG_MADDR   8'h20
`define PMID_REG_MDATA   8'h24
// control register fields
`define PMID_CTRL_LINK   0
`define PMID_CTRL_SOFT   1
// event bits
`define PMID_EV_WR       0
`define PMID_EV_START    1
`define PMID_EV_STOP     2
`define PMID_EV_TXDIS    3
// synchroniser reset pattern {scl,sda,txdis,fault,optlost,linkdown}
`define PMID_SYNC_RST    6'h38

`endif

//--- src/pmid_pkg.sv
// types shared by the identification and status block
// assumes pmid_params.svh is available on the include path
package pmid_pkg;

    typedef enum logic [3:0] {
        TW_IDLE, TW_DEV, TW_DEV_ACK, TW_WADDR, TW_WA_ACK,
        TW_WDATA, TW_WD_ACK, TW_RDATA, TW_MACK
    } pmid_twi_st_t;

    typedef struct packed {
        logic       en;
        logic [8:0] addr;
        logic [7:0] data;
    } pmid_wr_t;

    typedef struct packed {
        logic [4:0][15:0] word;
    } pmid_diag_t;

endpackage

//--- src/pmid_sync.sv
// two flip-flop synchroniser bank for asynchronous inputs
// assumes one clock and a clock enable that freezes it
`timescale 1ns/1ps
module pmid_sync #(
    parameter int         W   = 6,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pmid_sync_st_t;

    pmid_sync_st_t s;
    pmid_sync_st_t next_s;

    always_comb begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        q         = s.s2;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= {RST, RST};
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule

//--- src/pmid_top.sv
// module management side: two-wire id memory slave, status pins,
// ahb-lite register slave with interrupt
// assumes scl, sda and the status pins are asynchronous to hclk
//
// Behaviour
// - Written bytes are taken on clock rises and stored only if unprotected.
// - Read bits are put on the data line at clock falls.
// - The data line is shared; start and stop are data edges at clock high.
// - Memory is bytes, reachable by address or one after another.
// - Raw readings are reported; calibration lives at 56 to 95 of page A2h.
// - Five monitored quantities are reported; thresholds are preloaded.
// - The fault output is high on a laser fault and low otherwise.
// - The transmitter is on only while the disable input is low.
// - The presence pin is held at ground.
// - The lost-signal output is high on signal loss, low otherwise.
// - The host may disable the transmitter and read status over the bus.
// - Signal loss may mean no optical input or no link with the partner.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pmid_params.svh"
module pmid_top
    import pmid_pkg::*;
(
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // two-wire serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // status and control pins
    input  wire logic        tx_disable_in,
    input  wire logic        laser_fault_in,
    input  wire logic        rx_optical_lost_in,
    input  wire logic        link_down_in,
    output logic             tx_fault_out,
    output logic             tx_enable_out,
    output logic             rx_signal_lost_out,
    output logic             mod_present_n_out,
    // interrupt
    output logic             irq
);
    typedef struct packed {
        pmid_twi_st_t st;
        logic [3:0]   cnt;
        logic [7:0]   sh;
        logic [7:0]   ptr;
        logic         page;
        logic         rw;
        logic         nack;
        logic         sda_drv;
        logic         scl_d;
        logic         sda_d;
        logic         dp_valid;
        logic         dp_wr;
        logic [7:0]   dp_addr;
        logic [31:0]  hrdata;
        logic         hready;
        logic [1:0]   ctrl;
        pmid_diag_t   diag;
        logic [8:0]   maddr;
        logic [3:0]   irq_st;
        logic [3:0]   irq_en;
        logic         irq;
        logic         txdis_d;
        logic         tx_fault;
        logic         tx_en;
        logic         lost;
        logic         present_n;
    } pmid_top_st_t;

    pmid_top_st_t s;
    pmid_top_st_t next_s;

    logic [5:0] sy;
    pmid_wr_t   twi_wr;
    pmid_wr_t   fac_wr;
    logic [7:0] twi_data;
    logic [7:0] fac_data;
    logic       soft_dis;

    pmid_sync #(
        .W   (6),
        .RST (`PMID_SYNC_RST)
    ) u_sync (
        .clk  (hclk),
        .rstn (hresetn),
        .ce   (ce),
        .d    ({scl_in, sda_in, tx_disable_in, laser_fault_in,
                rx_optical_lost_in, link_down_in}),
        .q    (sy)
    );

    pmid_mem #(
        .PAGE (256)
    ) u_mem (
        .clk      (hclk),
        .rstn     (hresetn),
        .ce       (ce),
        .twi_wr   (twi_wr),
        .fac_wr   (fac_wr),
        .twi_addr ({s.page, s.ptr}),
        .fac_addr (s.maddr),
        .twi_data (twi_data),
        .fac_data (fac_data),
        .diag     (s.diag),
        .txdis    (s.txdis_d),
        .fault    (s.tx_fault),
        .lost     (s.lost),
        .soft_dis (soft_dis)
    );

    always_comb begin
        logic       scl;
        logic       sda;
        logic       rise;
        logic       fall;
        logic       start;
        logic       stop;
        logic [3:0] ev;
        logic [3:0] clr;
        logic [7:0] a;
        scl    = sy[5];
        sda    = sy[4];
        rise   = scl & ~s.scl_d;
        fall   = ~scl & s.scl_d;
        start  = scl & s.scl_d & s.sda_d & ~sda;
        stop   = scl & s.scl_d & ~s.sda_d & sda;
        ev     = '0;
        clr    = '0;
        a      = haddr[7:0];
        twi_wr = '0;
        fac_wr = '0;
        next_s = s;
        next_s.scl_d = scl;
        next_s.sda_d = sda;

        // two-wire protocol engine
        if (start) begin
            next_s.st      = TW_DEV;
            next_s.cnt     = '0;
            next_s.sda_drv = 1'b0;
            ev[`PMID_EV_START] = 1'b1;
        end else if (stop) begin
            next_s.st      = TW_IDLE;
            next_s.sda_drv = 1'b0;
            ev[`PMID_EV_STOP] = (s.st != TW_IDLE);
        end else begin
            unique case (s.st)
                TW_IDLE: begin
                    next_s.sda_drv = 1'b0;
                end
                TW_DEV, TW_WADDR, TW_WDATA: begin
                    if (rise) begin
                        next_s.sh  = {s.sh[6:0], sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end
                    if (fall && s.cnt == `PMID_LAST_BIT) begin
                        next_s.cnt     = '0;
                        next_s.sda_drv = 1'b1;
                        if (s.st == TW_DEV) begin
                            next_s.page = s.sh[1];
                            next_s.rw   = s.sh[0];
                            next_s.st   = TW_DEV_ACK;
                            if (s.sh[7:1] != `PMID_DEV_ID
                                && s.sh[7:1] != `PMID_DEV_DIAG) begin
                                next_s.sda_drv = 1'b0;
                                next_s.st      = TW_IDLE;
                            end
                        end else if (s.st == TW_WADDR) begin
                            next_s.ptr = s.sh;
                            next_s.st  = TW_WA_ACK;
                        end else begin
                            twi_wr.en   = 1'b1;
                            twi_wr.addr = {s.page, s.ptr};
                            twi_wr.data = s.sh;
                            next_s.ptr  = s.ptr + 8'h01;
                            next_s.st   = TW_WD_ACK;
                            ev[`PMID_EV_WR] = 1'b1;
                        end
                    end
                end
                TW_DEV_ACK, TW_WA_ACK, TW_WD_ACK: begin
                    if (fall) begin
                        if (s.st == TW_DEV_ACK && s.rw) begin
                            next_s.sh      = twi_data;
                            next_s.sda_drv = ~twi_data[7];
                            next_s.ptr     = s.ptr + 8'h01;
                            next_s.st      = TW_RDATA;
                        end else begin
                            next_s.sda_drv = 1'b0;
                            next_s.st = (s.st == TW_DEV_ACK) ? TW_WADDR
                                                             : TW_WDATA;
                        end
                    end
                end
                TW_RDATA: begin
                    if (rise) begin
                        next_s.cnt = s.cnt + 4'h1;
                    end
                    if (fall) begin
                        if (s.cnt == `PMID_LAST_BIT) begin
                            next_s.cnt     = '0;
                            next_s.sda_drv = 1'b0;
                            next_s.st      = TW_MACK;
                        end else begin
                            next_s.sh      = {s.sh[6:0], 1'b0};
                            next_s.sda_drv = ~s.sh[6];
                        end
                    end
                end
                TW_MACK: begin
                    if (rise) begin
                        next_s.nack = sda;
                    end
                    if (fall) begin
                        if (s.nack) begin
                            next_s.st = TW_IDLE;
                        end else begin
                            next_s.sh      = twi_data;
                            next_s.sda_drv = ~twi_data[7];
                            next_s.ptr     = s.ptr + 8'h01;
                            next_s.st      = TW_RDATA;
                        end
                    end
                end
            endcase
        end

        // ahb-lite data phase: writes
        next_s.hready = 1'b1;
        if (s.dp_valid && s.dp_wr) begin
            unique case (s.dp_addr)
                `PMID_REG_CTRL:    next_s.ctrl = hwdata[1:0];
                `PMID_REG_IRQ_CLR: clr = hwdata[3:0];
                `PMID_REG_IRQ_EN:  next_s.irq_en = hwdata[3:0];
                `PMID_REG_DIAG0:   next_s.diag.word[1:0] = hwdata;
                `PMID_REG_DIAG1:   next_s.diag.word[3:2] = hwdata;
                `PMID_REG_DIAG2:   next_s.diag.word[4] = hwdata[15:0];
                `PMID_REG_MADDR:   next_s.maddr = hwdata[8:0];
                `PMID_REG_MDATA: begin
                    fac_wr.en   = 1'b1;
                    fac_wr.addr = s.maddr;
                    fac_wr.data = hwdata[7:0];
                end
                default: ;
            endcase
        end

        // ahb-lite address phase: capture and prepare read data
        next_s.dp_valid = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            next_s.dp_wr   = hwrite;
            next_s.dp_addr = a;
            next_s.hrdata  = '0;
            unique case (a)
                `PMID_REG_CTRL:   next_s.hrdata[1:0] = s.ctrl;
                `PMID_REG_STATUS: next_s.hrdata[4:0] =
                    {s.st != TW_IDLE, s.lost, s.tx_en,
                     soft_dis | s.ctrl[`PMID_CTRL_SOFT], s.txdis_d};
                `PMID_REG_IRQ_ST: next_s.hrdata[3:0] = s.irq_st;
                `PMID_REG_IRQ_EN: next_s.hrdata[3:0] = s.irq_en;
                `PMID_REG_DIAG0:  next_s.hrdata = s.diag.word[1:0];
                `PMID_REG_DIAG1:  next_s.hrdata = s.diag.word[3:2];
                `PMID_REG_DIAG2:  next_s.hrdata[15:0] = s.diag.word[4];
                `PMID_REG_MADDR:  next_s.hrdata[8:0] = s.maddr;
                `PMID_REG_MDATA:  next_s.hrdata[7:0] = fac_data;
                default: ;
            endcase
        end

        // status and control pins
        next_s.txdis_d   = sy[3];
        ev[`PMID_EV_TXDIS] = sy[3] ^ s.txdis_d;
        next_s.tx_en     = ~sy[3] & ~soft_dis
                         & ~s.ctrl[`PMID_CTRL_SOFT];
        next_s.tx_fault  = sy[2];
        next_s.lost      = s.ctrl[`PMID_CTRL_LINK] ? sy[0]
                                                   : sy[1];
        next_s.present_n = 1'b0;

        // sticky events; a new event wins over its clear
        next_s.irq_st = (s.irq_st & ~clr) | ev;
        next_s.irq    = |(next_s.irq_st & next_s.irq_en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s         <= '0;
            s.st      <= TW_IDLE;
            s.scl_d   <= 1'b1;
            s.sda_d   <= 1'b1;
            s.hready  <= 1'b1;
            s.txdis_d <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign hreadyout          = s.hready;
    assign hresp              = 1'b0;
    assign hrdata             = s.hrdata;
    assign sda_out            = 1'b0;
    assign sda_oe_n           = ~s.sda_drv;
    assign tx_fault_out       = s.tx_fault;
    assign tx_enable_out      = s.tx_en;
    assign rx_signal_lost_out = s.lost;
    assign mod_present_n_out  = s.present_n;
    assign irq                = s.irq;
endmodule

//--- verification/pmid_host.sv
// host side two-wire master model: drives the clock, shares the data line
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module pmid_host (
    // serial lines
    output logic       scl,
    output logic       sda_rel,
    input  wire logic  sda,
    // bits seen in the last byte slot, strobe toggles per slot
    output logic [8:0] got,
    output logic       got_stb
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        got = 9'h0;
        got_stb = 1'b0;
    end
    // also a repeated start: data falls while the clock is high
    task start;
        sda_rel <= 1'b1;
        #40 scl <= 1'b1;
        #40 sda_rel <= 1'b0;
        #40 scl <= 1'b0;
        #40;
    endtask
    task stop;
        sda_rel <= 1'b0;
        #40 scl <= 1'b1;
        #40 sda_rel <= 1'b1;
        #40;
    endtask
    // a released bit lets the module drive; each slot sampled at clock high
    task xfer(input logic [7:0] b, input logic ninth);
        logic [8:0] v;
        v = {b, ninth};
        for (int i = 8; i >= 0; i--) begin
            sda_rel <= v[i];
            #40 scl <= 1'b1;
            #40 got = {got[7:0], sda};
            #40 scl <= 1'b0;
            #40;
        end
        got_stb = ~got_stb;
    endtask
endmodule

//--- verification/pmid_top_bench.sv
// self-checking bench of the module management block
// assumes pmid_host as serial master and the bound checker
`timescale 1ns/1ps
module pmid_top_bench;
    logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, rd_ph = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r = 32'h63D5;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        tx_disable_in = 1'b1, laser_fault_in = 1'b0;
    logic        rx_optical_lost_in = 1'b0, link_down_in = 1'b0;
    logic        hreadyout, hresp, sda_out, sda_oe_n, irq, scl, sda_rel;
    logic        tx_fault_out, tx_enable_out, rx_signal_lost_out;
    logic        mod_present_n_out, got_stb;
    logic [8:0]  got;
    wire         sda = sda_rel & (sda_oe_n | sda_out);
    logic [31:0] aq[$];
    logic [8:0]  sq[$];
    int          error_cnt = 0, n_compared = 0, cyc = 0;

    pmid_top uut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .tx_disable_in(tx_disable_in), .laser_fault_in(laser_fault_in),
        .rx_optical_lost_in(rx_optical_lost_in),
        .link_down_in(link_down_in), .tx_fault_out(tx_fault_out),
        .tx_enable_out(tx_enable_out),
        .rx_signal_lost_out(rx_signal_lost_out),
        .mod_present_n_out(mod_present_n_out), .irq(irq)
    );
    pmid_host host (
        .scl(scl), .sda_rel(sda_rel), .sda(sda), .got(got), .got_stb(got_stb)
    );

    always #2.5 hclk = ~hclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        aq.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask
    task sbyte(input logic [7:0] b, input logic n, input logic [8:0] e);
        sq.push_back(e);
        host.xfer(b, n);
    endtask
    task wr(input logic [7:0] b);
        sbyte(b, 1'b1, {b, 1'b0});
    endtask
    task rdb(input logic [7:0] e, input logic n);
        sbyte(8'hFF, n, {e, n});
    endtask
    task sel(input logic [7:0] d, input logic [7:0] o);
        host.start();
        wr(d);
        wr(o);
    endtask
    task rsel(input logic [7:0] d);
        host.start();
        wr(d);
    endtask

    // result watchers: each result takes the oldest note
    always @(posedge hclk) if (rd_ph) chk("hrdata", hrdata, aq.pop_front());
    always @(got_stb) if (hresetn === 1'b1)
        chk("serial", {23'h0, got}, {23'h0, sq.pop_front()});
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        logic lost;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            r = xs(r);
            ahb(1'b1, 8'h00, {30'h0, r[5:4]});
            tx_disable_in <= r[0];
            laser_fault_in <= r[1];
            rx_optical_lost_in <= r[2];
            link_down_in <= r[3];
            repeat (6) @(posedge hclk);
            lost = r[4] ? r[3] : r[2];
            chk("tx_fault_out", {31'h0, tx_fault_out}, {31'h0, r[1]});
            rd(8'h04, {28'h0, lost, ~r[0] & ~r[5], r[5], r[0]});
        end
        // clock enable low freezes the pin outputs
        ce <= 1'b0;
        laser_fault_in <= ~r[1];
        repeat (6) @(posedge hclk);
        chk("frozen", {31'h0, tx_fault_out}, {31'h0, r[1]});
        ce <= 1'b1;
        ahb(1'b1, 8'h00, 32'h0);
        tx_disable_in <= 1'b1;
        laser_fault_in <= 1'b1;
        rx_optical_lost_in <= 1'b0;
        link_down_in <= 1'b1;
        repeat (6) @(posedge hclk);
        ahb(1'b1, 8'h0C, 32'hF);
        ahb(1'b1, 8'h10, 32'h8);
        tx_disable_in <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h1);
        ahb(1'b1, 8'h08, 32'h0);
        rd(8'h08, 32'h8);
        ahb(1'b1, 8'h10, 32'h0);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h0);
        ahb(1'b1, 8'h0C, 32'h8);
        rd(8'h08, 32'h0);
        rd(8'h3C, 32'h0);
        // factory preload of a calibration byte and an id byte
        ahb(1'b1, 8'h20, 32'h138);
        ahb(1'b1, 8'h24, 32'h5A);
        ahb(1'b1, 8'h20, 32'h10);
        ahb(1'b1, 8'h24, 32'hC3);
        ahb(1'b1, 8'h0C, 32'hF);
        r = xs(r);
        sel(8'hA2, 8'h80);
        wr(r[7:0]);
        wr(r[15:8]);
        host.stop();
        rd(8'h08, 32'h7);
        sel(8'hA2, 8'h38);
        wr(8'hFF);
        host.stop();
        sel(8'hA2, 8'h7F);
        rsel(8'hA3);
        rdb(8'h00, 1'b0);
        rdb(r[7:0], 1'b0);
        rdb(r[15:8], 1'b1);
        host.stop();
        sel(8'hA2, 8'h38);
        rsel(8'hA3);
        rdb(8'h5A, 1'b1);
        host.stop();
        sel(8'hA0, 8'h10);
        rsel(8'hA1);
        rdb(8'hC3, 1'b1);
        host.stop();
        host.start();
        sbyte(8'hA4, 1'b1, {8'hA4, 1'b1});
        host.stop();
        sel(8'hA2, 8'h6E);
        wr(8'h40);
        host.stop();
        rd(8'h04, 32'h2);
        sel(8'hA2, 8'h6E);
        rsel(8'hA3);
        rdb(8'h44, 1'b1);
        host.stop();
        ahb(1'b1, 8'h20, 32'h180);
        rd(8'h24, {24'h0, r[7:0]});
        wrap_up();
    end
endmodule

//--- verification/pmid_top_chk.sv
// concurrent checks on the status pins and the serial data driver
// assumes bound to pmid_top, one clock domain
`timescale 1ns/1ps
module pmid_top_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_oe_n,
    // status pins
    input wire logic tx_disable_in,
    input wire logic laser_fault_in,
    input wire logic rx_optical_lost_in,
    input wire logic link_down_in,
    input wire logic tx_fault_out,
    input wire logic tx_enable_out,
    input wire logic rx_signal_lost_out,
    input wire logic mod_present_n_out,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);
    property p_present; mod_present_n_out == 1'b0; endproperty
    a_present: assert property (p_present)
        else $error("presence pin not low");
    property p_fault_hi; laser_fault_in [*5] |-> tx_fault_out; endproperty
    a_fault_hi: assert property (p_fault_hi)
        else $error("fault output missing");
    property p_fault_lo; !laser_fault_in [*5] |-> !tx_fault_out; endproperty
    a_fault_lo: assert property (p_fault_lo)
        else $error("fault output without fault");
    property p_txdis; tx_disable_in [*5] |-> !tx_enable_out; endproperty
    a_txdis: assert property (p_txdis)
        else $error("transmitter on while disabled");
    property p_lost_hi;
        (rx_optical_lost_in && link_down_in) [*5] |-> rx_signal_lost_out;
    endproperty
    a_lost_hi: assert property (p_lost_hi)
        else $error("lost signal not shown");
    property p_lost_lo;
        (!rx_optical_lost_in && !link_down_in) [*5] |-> !rx_signal_lost_out;
    endproperty
    a_lost_lo: assert property (p_lost_lo)
        else $error("lost signal shown in reception");
    property p_sda_fall;
        $changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_sda_fall: assert property (p_sda_fall)
        else $error("data driver changed away from clock fall");
    property p_sda_hold; scl_in [*4] |-> $stable(sda_oe_n); endproperty
    a_sda_hold: assert property (p_sda_hold)
        else $error("data driver changed while clock high");
    c_irq: cover property ($rose(irq));
    c_drive: cover property ($fell(sda_oe_n));
    c_lost: cover property ($rose(rx_signal_lost_out));
endmodule
bind pmid_top pmid_top_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .scl_in(scl_in),
    .sda_oe_n(sda_oe_n),
    .tx_disable_in(tx_disable_in), .laser_fault_in(laser_fault_in),
    .rx_optical_lost_in(rx_optical_lost_in), .link_down_in(link_down_in),
    .tx_fault_out(tx_fault_out), .tx_enable_out(tx_enable_out),
    .rx_signal_lost_out(rx_signal_lost_out),
    .mod_present_n_out(mod_present_n_out), .irq(irq)
);
